// ===== src/idle_powerdown_controller.sv
// Purpose: Idle and power-down sequencing with power control register
// Assumes: CPU core retires the instruction flagged by cpu_instr_done; wake
//          pins are asynchronous and synchronised here
// Notes: CPU state and RAM retention rely on the CPU clock enable staying low
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module idle_powerdown_controller #(
   parameter int KEYBOARD_WAKE_COUNT = pwr_pkg::KEYBOARD_WAKE_CLOCKS,
   parameter int RESET_HOLD_CYCLES = pwr_pkg::RESET_HOLD_OSC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // CPU core side
   input wire logic cpu_instr_done,
   input wire logic cpu_irq_vector,
   input wire logic cpu_external_program,
   // Interrupt sources (enabled and pending, from interrupt logic)
   input wire logic any_enabled_irq,
   input wire logic keyboard_irq,
   input wire logic usb_irq,
   // Asynchronous wake pins, active low
   input wire logic ext_int0_n,
   input wire logic external_interrupt_one_n,
   // Raw reset pin and supply-rise indication, asynchronous
   input wire logic reset_pin,
   input wire logic supply_rise,
   // Gated enables and pin control
   output pwr_pkg::clock_ctrl_t clock_ctrl,
   output pwr_pkg::pin_ctrl_t pin_ctrl,
   output logic cpu_reset,
   output logic ext1_first,
   // Serial port controls
   output logic double_baud_select,
   output logic framing_view_select
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   localparam int SYNC_EXT0 = 0;
   localparam int SYNC_EXT1 = 1;
   localparam int SYNC_RESET = 2;
   localparam int SYNC_SUPPLY = 3;
   localparam int SYNC_WIDTH = 4;
   // Two flops on every asynchronous pin before any logic reads it
   logic [SYNC_WIDTH-1:0] sync_a;
   logic [SYNC_WIDTH-1:0] sync_b;
   always_ff @(posedge aclk) begin
      sync_a <= {supply_rise, reset_pin, external_interrupt_one_n, ext_int0_n};
      sync_b <= sync_a;
   end
   wire ext0_low = ~sync_b[SYNC_EXT0];
   wire ext1_low = ~sync_b[SYNC_EXT1];
   wire reset_level = sync_b[SYNC_RESET];
   wire supply_level = sync_b[SYNC_SUPPLY];

   // ****************************************
   // Reset filter
   // ****************************************
   logic [15:0] reset_count;
   logic hw_reset;
   wire [15:0] reset_hold = 16'(RESET_HOLD_CYCLES);
   always_ff @(posedge aclk) begin
      if (!aresetn || !reset_level) begin
         reset_count <= 16'h0000;
      end else if (reset_count != reset_hold) begin
         reset_count <= reset_count + 16'h0001;
      end
   end
   // Pin reset acts only once it has stood high for the full hold time
   assign hw_reset = (reset_count == reset_hold);

   // ****************************************
   // Register address decode
   // ****************************************
   localparam int SEL_POWER_CONTROL = 0;
   localparam int SEL_WAKE_ENABLE = 1;
   localparam int SEL_STATUS = 2;
   localparam int SEL_WIDTH = 3;
   // One-hot register select, shared by the write and read paths
   function automatic logic [SEL_WIDTH-1:0] reg_select(input logic [11:0] addr);
      reg_select = '0;
      reg_select[SEL_POWER_CONTROL] = (addr == pwr_pkg::POWER_CONTROL_ADDR);
      reg_select[SEL_WAKE_ENABLE] = (addr == pwr_pkg::WAKE_ENABLE_ADDR);
      reg_select[SEL_STATUS] = (addr == pwr_pkg::STATUS_ADDR);
   endfunction

   // ****************************************
   // Power control register
   // ****************************************
   logic [7:0] power_control;
   logic [7:0] next_power_control;
   logic [3:0] wake_enable;
   pwr_pkg::mode_t mode;
   pwr_pkg::mode_t next_mode;
   logic [15:0] wake_count;
   logic supply_seen;

   logic aw_held;
   logic w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire [SEL_WIDTH-1:0] wr_sel = reg_select(aw_addr);
   wire [SEL_WIDTH-1:0] rd_sel = reg_select(s_axi_araddr);
   wire wr_pc = do_write && wr_sel[SEL_POWER_CONTROL] && w_strb[0];
   wire wr_we = do_write && wr_sel[SEL_WAKE_ENABLE] && w_strb[0];
   wire wr_hit = |wr_sel;

   wire supply_event = supply_level && !supply_seen;
   wire clear_req = cpu_irq_vector || hw_reset;
   wire [7:0] wr_byte = w_data[7:0] & pwr_pkg::SOFTWARE_MASK;

   // Write wins over the hardware clear; a supply rise wins over the write
   always_comb begin
      next_power_control = power_control;
      if (wr_pc) begin
         next_power_control = wr_byte;
      end else if (clear_req) begin
         next_power_control[pwr_pkg::IDLE_REQUEST_BIT] = 1'b0;
         next_power_control[pwr_pkg::POWERDOWN_REQUEST_BIT] = 1'b0;
      end
      if (supply_event) begin
         next_power_control[pwr_pkg::POWER_OFF_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || hw_reset) begin
         // Reset exit reinitialises register contents
         power_control <= pwr_pkg::POWER_CONTROL_RESET;
         supply_seen <= 1'b0;
      end else begin
         power_control <= next_power_control;
         supply_seen <= supply_level;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_enable <= 4'h0;
      end else if (wr_we) begin
         wake_enable <= w_data[3:0];
      end
   end

   // ****************************************
   // Mode sequencer
   // ****************************************
   wire idle_req = power_control[pwr_pkg::IDLE_REQUEST_BIT];
   wire pd_req = power_control[pwr_pkg::POWERDOWN_REQUEST_BIT];
   wire ext0_wake = wake_enable[pwr_pkg::WAKE_EXT0] && ext0_low;
   wire ext1_wake = wake_enable[pwr_pkg::WAKE_EXT1] && ext1_low;
   wire kb_wake = wake_enable[pwr_pkg::WAKE_KEYBOARD] && keyboard_irq;
   wire usb_wake = wake_enable[pwr_pkg::WAKE_USB] && usb_irq;
   logic ext_pending;
   logic kb_pending;
   logic ext1_seen;
   logic ext0_went_low;
   logic ext1_went_low;
   localparam logic [15:0] WAKE_COUNT_MAX = 16'hFFFF;
   wire any_wake = ext0_wake || ext1_wake || kb_wake || usb_wake;
   wire ext_release = ext_pending && !ext0_low && !ext1_low;
   // Whichever low pin is released first completes the exit
   wire first_release = ext_pending && ((ext0_went_low && !ext0_low)
      || (ext1_went_low && !ext1_low));
   // Counter is zero on the first wait cycle, so the wait lasts exactly the count
   wire [15:0] kb_last = 16'(KEYBOARD_WAKE_COUNT - 1);

   always_comb begin
      next_mode = mode;
      unique case (mode)
         pwr_pkg::MODE_RUN: begin
            // Request takes effect only after the writing instruction retires
            if (cpu_instr_done && pd_req) begin
               next_mode = pwr_pkg::MODE_POWERDOWN;
            end else if (cpu_instr_done && idle_req) begin
               next_mode = pwr_pkg::MODE_IDLE;
            end
         end
         pwr_pkg::MODE_IDLE: begin
            if (any_enabled_irq || !idle_req) begin
               next_mode = pwr_pkg::MODE_RUN;
            end
         end
         pwr_pkg::MODE_POWERDOWN: begin
            if (any_wake) begin
               next_mode = pwr_pkg::MODE_WAKE;
            end
         end
         pwr_pkg::MODE_WAKE: begin
            if (kb_pending && wake_count >= kb_last) begin
               next_mode = pwr_pkg::MODE_RUN;
            end else if (ext_pending && first_release) begin
               next_mode = pwr_pkg::MODE_RUN;
            end else if (!kb_pending && !ext_pending) begin
               next_mode = pwr_pkg::MODE_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || hw_reset) begin
         mode <= pwr_pkg::MODE_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // Wait counter restarts on every power-down cycle and saturates
   always_ff @(posedge aclk) begin
      if (!aresetn || hw_reset || mode == pwr_pkg::MODE_POWERDOWN) begin
         wake_count <= 16'h0000;
      end else if (mode == pwr_pkg::MODE_WAKE && wake_count != WAKE_COUNT_MAX) begin
         wake_count <= wake_count + 16'h0001;
      end
   end

   // Wake sources captured in power-down; a pin that goes low later joins in the wait
   always_ff @(posedge aclk) begin
      if (!aresetn || hw_reset) begin
         ext_pending <= 1'b0;
         kb_pending <= 1'b0;
         ext1_seen <= 1'b0;
         ext0_went_low <= 1'b0;
         ext1_went_low <= 1'b0;
      end else if (mode == pwr_pkg::MODE_POWERDOWN) begin
         ext_pending <= ext0_wake || ext1_wake;
         kb_pending <= kb_wake && !(ext0_wake || ext1_wake);
         ext1_seen <= ext1_wake && !ext0_wake;
         ext0_went_low <= ext0_wake;
         ext1_went_low <= ext1_wake;
      end else if (mode == pwr_pkg::MODE_WAKE) begin
         ext0_went_low <= ext0_went_low || ext0_wake;
         ext1_went_low <= ext1_went_low || ext1_wake;
      end
   end
   assign ext1_first = ext1_seen;
   wire unused_release = ext_release;

   // ****************************************
   // Clock enables and pins
   // ****************************************
   wire in_idle = (mode == pwr_pkg::MODE_IDLE);
   wire in_pd = (mode == pwr_pkg::MODE_POWERDOWN);
   wire in_wake = (mode == pwr_pkg::MODE_WAKE);
   // CPU stalls in every low-power state so its registers and PC hold
   assign clock_ctrl.cpu_clock_enable = !(in_idle || in_pd || in_wake);
   assign clock_ctrl.periph_clock_enable = !in_pd;
   // Oscillator restarts once a wake source is seen
   assign clock_ctrl.oscillator_enable = !in_pd;
   assign pin_ctrl.address_latch_strobe = !(in_pd || in_wake);
   assign pin_ctrl.program_store_strobe = !(in_pd || in_wake);
   assign pin_ctrl.hold_ports = in_idle || in_pd || in_wake;
   // Port 0 floats whenever the external program bus is parked
   assign pin_ctrl.port0_float = (in_idle || in_pd || in_wake) && cpu_external_program;
   assign pin_ctrl.port2_address = in_idle && cpu_external_program;
   assign cpu_reset = hw_reset;
   assign double_baud_select = power_control[pwr_pkg::DOUBLE_BAUD_SELECT];
   assign framing_view_select = power_control[pwr_pkg::FRAMING_VIEW_SELECT];

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   // Address and data are taken independently; the answer follows both
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pwr_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Status: mode in the low bits, then keyboard wait, then both pins released
   wire [1:0] status_mode = 2'(mode);
   wire [31:0] status_word = {28'h0000000, unused_release, kb_pending, status_mode};
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pwr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= pwr_pkg::RESP_OKAY;
         if (rd_sel[SEL_POWER_CONTROL]) begin
            s_axi_rdata <= {24'h000000, power_control};
         end else if (rd_sel[SEL_WAKE_ENABLE]) begin
            s_axi_rdata <= {28'h0000000, wake_enable};
         end else if (rd_sel[SEL_STATUS]) begin
            s_axi_rdata <= status_word;
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pwr_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ===== src/pwr_pkg.sv
// Purpose: Shared constants and types for the idle/power-down controller
// Assumes: AXI4-Lite register access, 50 MHz clock
// Notes: Register offset 0x87 is not word aligned, so it is kept as an index
package pwr_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] POWER_CONTROL_INDEX = 8'h87;
   localparam logic [7:0] WAKE_ENABLE_INDEX = 8'h88;
   localparam logic [7:0] STATUS_INDEX = 8'h89;
   localparam logic [11:0] POWER_CONTROL_ADDR = {2'h0, POWER_CONTROL_INDEX, 2'h0};
   localparam logic [11:0] WAKE_ENABLE_ADDR = {2'h0, WAKE_ENABLE_INDEX, 2'h0};
   localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_INDEX, 2'h0};
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h10;

   // ****************************************
   // Power control bit positions
   // ****************************************
   localparam int IDLE_REQUEST_BIT = 0;
   localparam int POWERDOWN_REQUEST_BIT = 1;
   localparam int GENERAL_FLAG_ZERO = 2;
   localparam int GENERAL_FLAG_ONE = 3;
   localparam int POWER_OFF_FLAG = 4;
   localparam int RESERVED_BIT = 5;
   localparam int FRAMING_VIEW_SELECT = 6;
   localparam int DOUBLE_BAUD_SELECT = 7;
   localparam logic [7:0] SOFTWARE_MASK = 8'hDF;

   // ****************************************
   // Wake enable bit positions
   // ****************************************
   localparam int WAKE_EXT0 = 0;
   localparam int WAKE_EXT1 = 1;
   localparam int WAKE_KEYBOARD = 2;
   localparam int WAKE_USB = 3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLOCK_HZ = 50_000_000;
   localparam int MACHINE_CYCLE_OSC = 12;
   localparam int RESET_HOLD_OSC = 24;
   localparam int KEYBOARD_WAKE_CLOCKS = 1024;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_IDLE,
      MODE_POWERDOWN,
      MODE_WAKE
   } mode_t;

   // Pin strobes and port steering
   typedef struct packed {
      logic address_latch_strobe;
      logic program_store_strobe;
      logic port0_float;
      logic port2_address;
      logic hold_ports;
   } pin_ctrl_t;

   // Clock enables for the two gated domains and the oscillator
   typedef struct packed {
      logic cpu_clock_enable;
      logic periph_clock_enable;
      logic oscillator_enable;
   } clock_ctrl_t;

endpackage

// ===== bench/cpu_core_model.sv
// Purpose: Behavioural CPU core, wake pins and reset pin facing the controller
// Assumes: The testbench calls these tasks from its main sequence
// Notes: Every pulse and pin change lands by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module cpu_core_model (
   // Clock
   input wire logic aclk,
   // Core strobes
   output logic cpu_instr_done,
   output logic cpu_irq_vector,
   // Wake and reset pins
   output logic ext_int0_n,
   output logic external_interrupt_one_n,
   output logic reset_pin
);
   initial begin
      cpu_instr_done = 1'b0;
      cpu_irq_vector = 1'b0;
      ext_int0_n = 1'b1;
      external_interrupt_one_n = 1'b1;
      reset_pin = 1'b0;
   end
   task automatic retire();
      @(posedge aclk);
      cpu_instr_done <= 1'b1;
      @(posedge aclk);
      cpu_instr_done <= 1'b0;
   endtask
   task automatic take_vector();
      @(posedge aclk);
      cpu_irq_vector <= 1'b1;
      @(posedge aclk);
      cpu_irq_vector <= 1'b0;
   endtask
   // Pin held low long enough for restart and synchronising
   task automatic pin_wake(input logic one, input int n);
      @(posedge aclk);
      if (one) external_interrupt_one_n <= 1'b0;
      else ext_int0_n <= 1'b0;
      repeat (n) @(posedge aclk);
      if (one) external_interrupt_one_n <= 1'b1;
      else ext_int0_n <= 1'b1;
   endtask
   task automatic reset_hold(input int n);
      @(posedge aclk);
      reset_pin <= 1'b1;
      repeat (n) @(posedge aclk);
      reset_pin <= 1'b0;
   endtask
endmodule

// ===== bench/idle_powerdown_controller_asserts.sv
// Purpose: Port-level checks of modes, strobes and register bus answers
// Assumes: One clock domain, synchronous active-low reset
// Notes: A USB wake leaves the wait state after one cycle, so it is excluded from the wake check
`timescale 1ns/1ps
module idle_powerdown_controller_asserts (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Mode side
   input wire logic usb_irq,
   input wire pwr_pkg::clock_ctrl_t clock_ctrl,
   input wire pwr_pkg::pin_ctrl_t pin_ctrl,
   input wire logic cpu_reset,
   input wire logic double_baud_select
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   pd_strobes_a: assert property (!clock_ctrl.oscillator_enable |->
      !pin_ctrl.address_latch_strobe && !pin_ctrl.program_store_strobe)
      else $error("strobes high with oscillator stopped");
   osc_periph_a: assert property (clock_ctrl.oscillator_enable |->
      clock_ctrl.periph_clock_enable) else $error("peripheral clock gated while running");
   osc_off_a: assert property (!clock_ctrl.oscillator_enable |-> clock_ctrl == 3'b000)
      else $error("enable left on in power-down");
   baud_write_a: assert property ($changed(double_baud_select) && !cpu_reset
      && !$past(cpu_reset) |-> ##[0:1] s_axi_bvalid) else $error("baud bit changed without write");
   bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   rdata_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   reserved_zero_a: assert property (s_axi_rvalid |-> !s_axi_rdata[5])
      else $error("reserved bit read as one");
   reset_run_a: assert property ($past(cpu_reset) && cpu_reset |-> clock_ctrl == 3'b111)
      else $error("clocks gated during pin reset");
   wake_start_a: assert property ($rose(clock_ctrl.oscillator_enable) && !cpu_reset
      && !usb_irq && !$past(usb_irq) |-> !clock_ctrl.cpu_clock_enable)
      else $error("cpu clock on at oscillator restart");
   idle_seen_c: cover property (clock_ctrl == 3'b011 && pin_ctrl.address_latch_strobe);
   pd_seen_c: cover property (clock_ctrl == 3'b000);
   reset_seen_c: cover property (cpu_reset);
endmodule

// ===== bench/test_idle_powerdown_controller.sv
// Purpose: Self-checking bench for the idle and power-down controller
// Assumes: Shortened keyboard wait and reset filter counts
// Notes: Bus signals are sampled at the falling edge and changed after the rising edge
`timescale 1ns/1ps
`define CHK(g, e) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("[ERR] %0t got %h expected %h", $time, (g), (e)); \
   end \
end
module test_idle_powerdown_controller;
   localparam int KB = 16;
   localparam int RH = 4;
   localparam logic [11:0] PC = pwr_pkg::POWER_CONTROL_ADDR;
   localparam logic [11:0] WE = pwr_pkg::WAKE_ENABLE_ADDR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic cpu_instr_done, cpu_irq_vector, ext_int0_n, external_interrupt_one_n, reset_pin;
   logic cpu_external_program = 1'b0, any_enabled_irq = 1'b0, keyboard_irq = 1'b0;
   logic usb_irq = 1'b0, supply_rise = 1'b1;
   pwr_pkg::clock_ctrl_t clock_ctrl;
   pwr_pkg::pin_ctrl_t pin_ctrl;
   logic cpu_reset, ext1_first, double_baud_select, framing_view_select;
   int mismatches = 0, check_count = 0, cycles = 0, n;
   idle_powerdown_controller #(.KEYBOARD_WAKE_COUNT(KB), .RESET_HOLD_CYCLES(RH))
      i_idle_powerdown_controller (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_instr_done, .cpu_irq_vector,
      .cpu_external_program, .any_enabled_irq, .keyboard_irq, .usb_irq, .ext_int0_n,
      .external_interrupt_one_n, .reset_pin, .supply_rise, .clock_ctrl, .pin_ctrl, .cpu_reset,
      .ext1_first, .double_baud_select, .framing_view_select);
   cpu_core_model i_cpu_core_model (.aclk, .cpu_instr_done, .cpu_irq_vector, .ext_int0_n,
      .external_interrupt_one_n, .reset_pin);
   always #10 aclk = ~aclk;
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic settle(input int k);
      repeat (k) @(negedge aclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic aw_t, w_t, b_t;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw_t = s_axi_awready;
         w_t = s_axi_wready;
         b_t = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
      end while (b_t !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      logic ar_t, r_t;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_t = s_axi_arready;
         r_t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
      end while (r_t !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(PC); `CHK(d, 32'h0000_0010)
      wr(PC, 32'h0000_00FF); `CHK(r, pwr_pkg::RESP_OKAY)
      rd(PC); `CHK(d[7:0], 8'hDF)
      `CHK({double_baud_select, framing_view_select}, 2'b11)
      wr(PC, 32'h0000_000C);
      rd(PC); `CHK(d[7:0], 8'h0C)
      `CHK({double_baud_select, framing_view_select}, 2'b00)
      rd(12'h7F0); `CHK({r, d}, {pwr_pkg::RESP_SLVERR, 32'h0000_0000})
      wr(12'h7F0, 32'h0000_0001); `CHK(r, pwr_pkg::RESP_SLVERR)
      // Idle with external program memory
      cpu_external_program <= 1'b1;
      wr(PC, 32'h0000_0005);
      i_cpu_core_model.retire();
      settle(2); `CHK(clock_ctrl, 3'b011)
      `CHK(pin_ctrl[4:2], 3'b111)
      `CHK(pin_ctrl.port2_address, 1'b1)
      `CHK(pin_ctrl.hold_ports, 1'b1)
      rd(pwr_pkg::STATUS_ADDR); `CHK(d[1:0], 2'h1)
      any_enabled_irq <= 1'b1;
      i_cpu_core_model.take_vector();
      settle(2); `CHK(clock_ctrl.cpu_clock_enable, 1'b1)
      @(posedge aclk);
      any_enabled_irq <= 1'b0;
      cpu_external_program <= 1'b0;
      rd(PC); `CHK(d[7:0], 8'h04)
      // Power-down with both request bits, woken by pin one, with pin zero going low during the wait
      wr(WE, 32'h0000_0003);
      wr(PC, 32'h0000_0007);
      i_cpu_core_model.retire();
      settle(2); `CHK({clock_ctrl, pin_ctrl[4:2]}, 6'b000000)
      fork
         i_cpu_core_model.pin_wake(1'b1, 12);
         begin
            settle(3);
            i_cpu_core_model.pin_wake(1'b0, 24);
         end
      join_none
      settle(10); `CHK(clock_ctrl, 3'b011)
      while (clock_ctrl.cpu_clock_enable !== 1'b1) settle(1);
      `CHK(ext1_first, 1'b1)
      i_cpu_core_model.take_vector();
      rd(PC); `CHK(d[7:0], 8'h04)
      `CHK(clock_ctrl, 3'b111)
      wait fork;
      // Keyboard wake after power-down
      wr(WE, 32'h0000_0004);
      wr(PC, 32'h0000_0006);
      i_cpu_core_model.retire();
      settle(2); `CHK(clock_ctrl.oscillator_enable, 1'b0)
      @(posedge aclk);
      keyboard_irq <= 1'b1;
      n = 0;
      settle(1);
      while (clock_ctrl.cpu_clock_enable !== 1'b1) begin
         if (clock_ctrl.oscillator_enable) n++;
         settle(1);
      end
      `CHK(n, KB)
      @(posedge aclk);
      keyboard_irq <= 1'b0;
      i_cpu_core_model.take_vector();
      rd(PC); `CHK(d[7:0], 8'h04)
      // Reset pin ends power-down and reloads the register
      wr(PC, 32'h0000_000E);
      i_cpu_core_model.retire();
      settle(2); `CHK(clock_ctrl, 3'b000)
      fork
         i_cpu_core_model.reset_hold(RH + 8);
         begin
            settle(10); `CHK({cpu_reset, clock_ctrl}, 4'b1111)
         end
      join
      settle(3);
      rd(PC); `CHK(d[7:0], 8'h10)
      final_report();
   end
endmodule
bind idle_powerdown_controller idle_powerdown_controller_asserts i_idle_powerdown_controller_asserts (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .usb_irq(usb_irq), .clock_ctrl(clock_ctrl), .pin_ctrl(pin_ctrl), .cpu_reset(cpu_reset),
   .double_baud_select(double_baud_select));
